// ---- shared/ccr_pkg.sv ----
// Purpose: Constants for the clock IC control and identification registers
// Assumes: 50 MHz core clock, byte-wide register port behind the serial
//          configuration interface
// Notes: Offsets, field positions, reset values and timing counts live here
`default_nettype none

package ccr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PN_HI = 8'h86;
  localparam logic [7:0] ADDR_PN_LO_REV = 8'h87;
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_FAST = 8'h89;
  localparam logic [7:0] ADDR_LOS_UP = 8'h8a;
  localparam logic [7:0] ADDR_LOS_LO = 8'h8b;

  // Field positions
  localparam int CTRL_SOFT_RST_BIT = 7;
  localparam int CTRL_CAL_BIT = 6;
  localparam int FAST_BIT = 0;
  localparam int LOSUP_IN2_BIT = 1;
  localparam int LOSUP_IN1_BIT = 0;
  localparam int LOSLO_IN2_BIT = 5;
  localparam int LOSLO_IN1_BIT = 4;
  localparam int LOSLO_FOS2_BIT = 1;
  localparam int LOSLO_FOS1_BIT = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic FAST_RST = 1'b0;
  localparam logic [1:0] LOS_UP_RST = 2'h3;
  localparam logic [7:0] LOS_LO_RST = 8'hff;

  // Signal-loss monitor modes
  typedef enum logic [1:0] {
    LOS_OFF = 2'h0,
    LOS_RSVD = 2'h1,
    LOS_ALT = 2'h2,
    LOS_STD = 2'h3
  } ccr_los_mode_t;

  // Calibration sequence; one bit changes per step except wait-lock back to idle
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RUN = 2'h1,
    CAL_WAIT_LOCK = 2'h3
  } ccr_cal_state_t;

  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int SOFT_RST_MS = 10;
  localparam int SOFT_RST_CYCLES = SOFT_RST_MS * (CLK_HZ / 1000);
  localparam int SOFT_CNT_W = 20;
  localparam int CAL_RUN_CYCLES = 1000;
  localparam int CAL_CNT_W = 10;
  localparam int STD_WIN_CYCLES = 64;
  localparam int ALT_WIN_CYCLES = 256;
  localparam int ALT_MISS_COUNT = 2;
  localparam int WIN_CNT_W = 9;

endpackage

`default_nettype wire

// ---- logic/ccr_ctrl_regs.sv ----
// Purpose: Control and identification registers of a clock multiplier
// Assumes: Serial port already decoded into byte reads and writes
// Notes: Soft reset blocks the register port for its whole duration
`default_nettype none

module ccr_ctrl_regs #(
  parameter int unsigned SOFT_RST_CYCLES = ccr_pkg::SOFT_RST_CYCLES,
  parameter logic [11:0] PART_NUMBER_CODE = 12'h5a5, // Arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h3 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // PLL and input pins
  input wire logic pll_locked_pin,
  input wire logic freq_shift_pin,
  input wire logic [1:0] clock_input_pin,
  // PLL control and status
  output logic loss_of_lock_alarm,
  output logic clock_outputs_enable,
  output logic fast_acquire_enable,
  output logic loop_bw_fast,
  output logic calibration_busy,
  // Signal-loss monitoring
  output logic [1:0] input1_signal_loss_enable,
  output logic [1:0] input2_signal_loss_enable,
  output logic [1:0] signal_loss_monitor
);

  // Mode of one input from its split enable bits
  function automatic ccr_pkg::ccr_los_mode_t los_mode(input logic up,
                                                      input logic lo);
    los_mode = ccr_pkg::ccr_los_mode_t'({up, lo});
  endfunction
  // Synchroniser stages: 0 lock, 1 freq shift, 3:2 clock inputs
  logic [3:0] s1_reg, s2_reg, s3_reg, acc_reg;
  logic [3:0] acc_next;
  // Control state
  logic soft_act_reg, soft_act_next, fast_reg, fast_next;
  logic [ccr_pkg::SOFT_CNT_W-1:0] soft_cnt_reg, soft_cnt_next;
  ccr_pkg::ccr_cal_state_t cal_state_reg, cal_state_next;
  logic [ccr_pkg::CAL_CNT_W-1:0] cal_cnt_reg, cal_cnt_next;
  logic [1:0] los_up_reg, los_up_next;
  logic [7:0] los_lo_reg, los_lo_next, rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next, lol_reg, lol_next, oe_reg, oe_next;
  logic bw_reg, bw_next, busy_reg, busy_next;
  // Monitor state
  logic [ccr_pkg::WIN_CNT_W-1:0] win_reg [2], win_next [2];
  logic [1:0] miss_reg [2], miss_next [2], loss_reg, loss_next;
  // Decoded strobes
  logic wr_ok, ctrl_wr, cal_start, shift_rise;
  logic [1:0] clk_edge;
  // Accepted pin levels change only once stages two and three agree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      acc_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : acc_reg[i];
    end
  end

  assign wr_ok = reg_wr && !soft_act_reg;
  assign ctrl_wr = wr_ok && (reg_addr == ccr_pkg::ADDR_CTRL);
  assign shift_rise = acc_next[1] && !acc_reg[1];
  assign cal_start = (ctrl_wr && reg_wdata[ccr_pkg::CTRL_CAL_BIT])
                     || shift_rise;
  assign clk_edge = acc_next[3:2] ^ acc_reg[3:2];

  // Control next state: soft reset, calibration, config, read port
  always_comb begin
    soft_act_next = soft_act_reg;
    soft_cnt_next = soft_cnt_reg;
    cal_state_next = cal_state_reg;
    cal_cnt_next = cal_cnt_reg;
    fast_next = fast_reg;
    los_up_next = los_up_reg;
    los_lo_next = los_lo_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    // Soft reset window, counted so the host lockout is honoured
    if (soft_act_reg) begin
      if (soft_cnt_reg == ccr_pkg::SOFT_CNT_W'(SOFT_RST_CYCLES - 1)) begin
        soft_act_next = 1'b0;
      end else begin
        soft_cnt_next = soft_cnt_reg + 1'b1;
      end
    end else if (ctrl_wr && reg_wdata[ccr_pkg::CTRL_SOFT_RST_BIT]) begin
      soft_act_next = 1'b1;
      soft_cnt_next = '0;
    end
    // Calibration sequence; a new start restarts it
    case (cal_state_reg)
      ccr_pkg::CAL_IDLE: begin
        cal_cnt_next = '0;
        if (cal_start) begin
          cal_state_next = ccr_pkg::CAL_RUN;
        end
      end
      ccr_pkg::CAL_RUN: begin
        if (cal_start) begin
          cal_cnt_next = '0;
        end else if (cal_cnt_reg ==
                     ccr_pkg::CAL_CNT_W'(ccr_pkg::CAL_RUN_CYCLES - 1)) begin
          cal_state_next = ccr_pkg::CAL_WAIT_LOCK;
        end else begin
          cal_cnt_next = cal_cnt_reg + 1'b1;
        end
      end
      ccr_pkg::CAL_WAIT_LOCK: begin
        if (cal_start) begin
          cal_state_next = ccr_pkg::CAL_RUN;
          cal_cnt_next = '0;
        end else if (acc_reg[0]) begin
          cal_state_next = ccr_pkg::CAL_IDLE;
        end
      end
      default: cal_state_next = ccr_pkg::CAL_IDLE;
    endcase
    // Register writes; only defined bits are stored
    if (wr_ok && reg_addr == ccr_pkg::ADDR_FAST) begin
      fast_next = reg_wdata[ccr_pkg::FAST_BIT];
    end
    if (wr_ok && reg_addr == ccr_pkg::ADDR_LOS_UP) begin
      los_up_next[1] = reg_wdata[ccr_pkg::LOSUP_IN2_BIT];
      los_up_next[0] = reg_wdata[ccr_pkg::LOSUP_IN1_BIT];
    end
    if (wr_ok && reg_addr == ccr_pkg::ADDR_LOS_LO) begin
      los_lo_next[ccr_pkg::LOSLO_IN2_BIT] =
        reg_wdata[ccr_pkg::LOSLO_IN2_BIT];
      los_lo_next[ccr_pkg::LOSLO_IN1_BIT] =
        reg_wdata[ccr_pkg::LOSLO_IN1_BIT];
      los_lo_next[ccr_pkg::LOSLO_FOS2_BIT] =
        reg_wdata[ccr_pkg::LOSLO_FOS2_BIT];
      los_lo_next[ccr_pkg::LOSLO_FOS1_BIT] =
        reg_wdata[ccr_pkg::LOSLO_FOS1_BIT];
    end
    // Read data; unmapped and reserved bits give zero, except reserved bits of ADDR_LOS_LO, which read one
    if (reg_rd && !soft_act_reg) begin
      rvalid_next = 1'b1;
      case (reg_addr)
        ccr_pkg::ADDR_PN_HI: rdata_next = PART_NUMBER_CODE[11:4];
        ccr_pkg::ADDR_PN_LO_REV: begin
          rdata_next = {PART_NUMBER_CODE[3:0], REVISION_CODE};
        end
        ccr_pkg::ADDR_CTRL: begin
          rdata_next = 8'h00;
          rdata_next[ccr_pkg::CTRL_CAL_BIT] =
            (cal_state_reg != ccr_pkg::CAL_IDLE);
        end
        ccr_pkg::ADDR_FAST: rdata_next = {7'h00, fast_reg};
        ccr_pkg::ADDR_LOS_UP: rdata_next = {6'h00, los_up_reg};
        ccr_pkg::ADDR_LOS_LO: rdata_next = los_lo_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    // Soft reset returns calibration and config registers to defaults, like the pin
    if (soft_act_next) begin
      cal_state_next = ccr_pkg::CAL_IDLE;
      cal_cnt_next = '0;
      fast_next = ccr_pkg::FAST_RST;
      los_up_next = ccr_pkg::LOS_UP_RST;
      los_lo_next = ccr_pkg::LOS_LO_RST;
    end
  end
  // Output terms, derived from next values except the registered lock level acc_reg[0], so they stay in step
  always_comb begin
    busy_next = (cal_state_next != ccr_pkg::CAL_IDLE);
    lol_next = soft_act_next || busy_next || !acc_reg[0];
    oe_next = !soft_act_next;
    bw_next = fast_next && lol_next;
  end

  // Monitor next state; alternate mode needs repeated empty windows
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      win_next[i] = win_reg[i];
      miss_next[i] = miss_reg[i];
      loss_next[i] = loss_reg[i];
      case (soft_act_reg ? ccr_pkg::LOS_OFF :
            los_mode(los_up_reg[i], los_lo_reg[ccr_pkg::LOSLO_IN1_BIT + i]))
        ccr_pkg::LOS_STD: begin
          if (clk_edge[i]) begin
            win_next[i] = '0;
            loss_next[i] = 1'b0;
          end else if (win_reg[i] == ccr_pkg::WIN_CNT_W'(
                       ccr_pkg::STD_WIN_CYCLES - 1)) begin
            loss_next[i] = 1'b1;
          end else begin
            win_next[i] = win_reg[i] + 1'b1;
          end
          miss_next[i] = '0;
        end
        ccr_pkg::LOS_ALT: begin
          if (clk_edge[i]) begin
            win_next[i] = '0;
            miss_next[i] = '0;
            loss_next[i] = 1'b0;
          end else if (win_reg[i] == ccr_pkg::WIN_CNT_W'(
                       ccr_pkg::ALT_WIN_CYCLES - 1)) begin
            win_next[i] = '0;
            if (miss_reg[i] == 2'(ccr_pkg::ALT_MISS_COUNT - 1)) begin
              loss_next[i] = 1'b1;
            end else begin
              miss_next[i] = miss_reg[i] + 1'b1;
            end
          end else begin
            win_next[i] = win_reg[i] + 1'b1;
          end
        end
        default: begin
          // Off, reserved code and soft reset clear the monitor
          win_next[i] = '0;
          miss_next[i] = '0;
          loss_next[i] = 1'b0;
        end
      endcase
    end
  end
  // All state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      acc_reg <= 4'h0;
      soft_act_reg <= 1'b0;
      soft_cnt_reg <= '0;
      cal_state_reg <= ccr_pkg::CAL_IDLE;
      cal_cnt_reg <= '0;
      fast_reg <= ccr_pkg::FAST_RST;
      los_up_reg <= ccr_pkg::LOS_UP_RST;
      los_lo_reg <= ccr_pkg::LOS_LO_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      lol_reg <= 1'b1;
      oe_reg <= 1'b0;
      bw_reg <= 1'b0;
      busy_reg <= 1'b0;
      win_reg <= '{default: '0};
      miss_reg <= '{default: 2'h0};
      loss_reg <= 2'h0;
    end else begin
      s1_reg <= {clock_input_pin, freq_shift_pin, pll_locked_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      acc_reg <= acc_next;
      soft_act_reg <= soft_act_next;
      soft_cnt_reg <= soft_cnt_next;
      cal_state_reg <= cal_state_next;
      cal_cnt_reg <= cal_cnt_next;
      fast_reg <= fast_next;
      los_up_reg <= los_up_next;
      los_lo_reg <= los_lo_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      lol_reg <= lol_next;
      oe_reg <= oe_next;
      bw_reg <= bw_next;
      busy_reg <= busy_next;
      win_reg <= win_next;
      miss_reg <= miss_next;
      loss_reg <= loss_next;
    end
  end

  // Ports straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign reg_rdata_valid = rvalid_reg;
  assign loss_of_lock_alarm = lol_reg;
  assign clock_outputs_enable = oe_reg;
  assign fast_acquire_enable = fast_reg;
  assign loop_bw_fast = bw_reg;
  assign calibration_busy = busy_reg;
  assign input1_signal_loss_enable =
    {los_up_reg[0], los_lo_reg[ccr_pkg::LOSLO_IN1_BIT]};
  assign input2_signal_loss_enable =
    {los_up_reg[1], los_lo_reg[ccr_pkg::LOSLO_IN2_BIT]};
  assign signal_loss_monitor = loss_reg;
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_soft_outputs_off: assert property (
    ctrl_wr && reg_wdata[ccr_pkg::CTRL_SOFT_RST_BIT]
    |=> !clock_outputs_enable && loss_of_lock_alarm
        && !fast_acquire_enable && input1_signal_loss_enable == 2'h3)
    else $error("soft reset did not disable outputs and clear config");
  a_soft_port_blocked: assert property (
    soft_act_reg && reg_rd |=> !reg_rdata_valid)
    else $error("read answered during soft reset");
  a_cal_starts: assert property (
    cal_start && !soft_act_next
    |=> calibration_busy ##1 (calibration_busy || !clock_outputs_enable))
    else $error("calibration did not start");
  a_cal_bit_reads: assert property (
    reg_rd && !soft_act_reg && reg_addr == ccr_pkg::ADDR_CTRL
    |=> reg_rdata[ccr_pkg::CTRL_CAL_BIT] == $past(calibration_busy)
        && reg_rdata[ccr_pkg::CTRL_SOFT_RST_BIT] == 1'b0)
    else $error("control read does not show calibration state");
  a_cal_lol_high: assert property (
    calibration_busy |-> loss_of_lock_alarm)
    else $error("alarm low during calibration");
  a_cal_done_low: assert property (
    $fell(calibration_busy) && clock_outputs_enable |-> !loss_of_lock_alarm)
    else $error("alarm not low after calibration");
  a_lol_unlocked: assert property (
    !acc_reg[0] |=> loss_of_lock_alarm)
    else $error("alarm low while unlocked");
  a_auto_cal: assert property (
    shift_rise && !soft_act_next |=> calibration_busy)
    else $error("frequency shift did not start calibration");
  a_fast_bw: assert property (
    loop_bw_fast |-> fast_acquire_enable && loss_of_lock_alarm)
    else $error("wide bandwidth without fast acquire");
  a_id_read: assert property (
    reg_rd && !soft_act_reg && reg_addr == ccr_pkg::ADDR_PN_LO_REV
    |=> reg_rdata == {PART_NUMBER_CODE[3:0], REVISION_CODE})
    else $error("wrong identification read");
  a_rsvd_zero: assert property (
    reg_rd && !soft_act_reg && reg_addr == ccr_pkg::ADDR_FAST
    |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
  a_los_off: assert property (
    (input1_signal_loss_enable == 2'h0) [*2] |-> !signal_loss_monitor[0])
    else $error("monitor reports loss while disabled");
  c_soft_reset: cover property ($fell(soft_act_reg));
  c_cal_done: cover property ($fell(calibration_busy));
  c_alt_loss: cover property (
    input2_signal_loss_enable == 2'h2 && $rose(signal_loss_monitor[1]));
  c_std_loss: cover property (
    input1_signal_loss_enable == 2'h3 && $rose(signal_loss_monitor[0]));

endmodule

`default_nettype wire

// ---- bench/ccr_host_model.sv ----
// Purpose: Host controller model on the byte register port
// Assumes: Strobes change on the falling clock edge, one cycle wide
// Notes: Idle address and data show the inverse of the last value
`default_nettype none

module ccr_host_model #(
  parameter int unsigned RST_WAIT = 24
) (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One write strobe, then junk on the released lines
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read strobe; data and valid taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata_valid;
    d = reg_rdata;
  endtask

  // Port stays silent while the soft reset runs
  task automatic settle();
    repeat (RST_WAIT) @(negedge clk);
  endtask

  // Read-modify-write keeps the upper bits untouched
  task automatic set_fast(input logic on);
    logic [7:0] d;
    logic v;
    rd(ccr_pkg::ADDR_FAST, d, v);
    wr(ccr_pkg::ADDR_FAST, {d[7:1], on});
  endtask

  // Never programs the reserved monitor code
  task automatic set_los(input logic [1:0] m1, input logic [1:0] m2);
    logic [7:0] d;
    logic [7:0] u;
    logic v;
    if (m1 != 2'h1 && m2 != 2'h1) begin
      rd(ccr_pkg::ADDR_LOS_UP, u, v);
      rd(ccr_pkg::ADDR_LOS_LO, d, v);
      // Raise upper halves first so no pair passes through 01
      wr(ccr_pkg::ADDR_LOS_UP, {6'h00, u[1] | m2[1], u[0] | m1[1]});
      wr(ccr_pkg::ADDR_LOS_LO, {d[7:6], m2[0], m1[0], d[3:0]});
      wr(ccr_pkg::ADDR_LOS_UP, {6'h00, m2[1], m1[1]});
    end
  endtask

endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the control and id registers
// Assumes: Inputs change on the falling clock edge
// Notes: Soft reset shortened to 20 cycles to keep the run brief
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SRC = 20;
  localparam logic [11:0] PN = 12'h3c9; // Arbitrary value
  localparam logic [3:0] REV = 4'h6; // Arbitrary value

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pll_locked_pin = 1'b1;
  logic freq_shift_pin = 1'b0;
  logic [1:0] clock_input_pin = 2'h0;
  logic in_run = 1'b1;
  logic reg_wr, reg_rd, reg_rdata_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic loss_of_lock_alarm, clock_outputs_enable, fast_acquire_enable;
  logic loop_bw_fast, calibration_busy;
  logic [1:0] input1_signal_loss_enable, input2_signal_loss_enable;
  logic [1:0] signal_loss_monitor;
  int bad_count = 0;
  int num_checks = 0;

  // 50 MHz core clock
  always #10 clk = ~clk;

  // Slow input clocks, stoppable to provoke signal loss
  always begin
    repeat (4) @(negedge clk);
    if (in_run) begin
      clock_input_pin = ~clock_input_pin;
    end
  end

  ccr_ctrl_regs #(.SOFT_RST_CYCLES(SRC), .PART_NUMBER_CODE(PN),
    .REVISION_CODE(REV)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .pll_locked_pin(pll_locked_pin),
    .freq_shift_pin(freq_shift_pin), .clock_input_pin(clock_input_pin),
    .loss_of_lock_alarm(loss_of_lock_alarm),
    .clock_outputs_enable(clock_outputs_enable),
    .fast_acquire_enable(fast_acquire_enable),
    .loop_bw_fast(loop_bw_fast), .calibration_busy(calibration_busy),
    .input1_signal_loss_enable(input1_signal_loss_enable),
    .input2_signal_loss_enable(input2_signal_loss_enable),
    .signal_loss_monitor(signal_loss_monitor));

  ccr_host_model #(.RST_WAIT(SRC + 4)) i_host (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  // Verdict and end of run, shared by timeouts
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Four-state compare
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Read one register, expect a valid pulse and the value
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host.rd(a, d, v);
    chk(8'(v), 8'h01);
    chk(d, e);
  endtask

  // Bounded wait for the calibration to finish
  task automatic wait_idle(output int n);
    n = 0;
    while (calibration_busy !== 1'b0) begin
      n++;
      if (n > 1200) begin
        bad_count++;
        wrap_up();
      end
      @(negedge clk);
    end
  endtask

  // Identity, reset values, read-only and unmapped places
  task automatic t_ids();
    rchk(ccr_pkg::ADDR_PN_HI, PN[11:4]);
    rchk(ccr_pkg::ADDR_PN_LO_REV, {PN[3:0], REV});
    i_host.wr(ccr_pkg::ADDR_PN_HI, ~PN[11:4]);
    rchk(ccr_pkg::ADDR_PN_HI, PN[11:4]);
    rchk(ccr_pkg::ADDR_CTRL, 8'h00);
    rchk(ccr_pkg::ADDR_FAST, 8'h00);
    i_host.wr(ccr_pkg::ADDR_LOS_UP, 8'hff);
    rchk(ccr_pkg::ADDR_LOS_UP, 8'h03);
    rchk(ccr_pkg::ADDR_LOS_LO, 8'hff);
    rchk(8'h90, 8'h00);
    chk(8'(clock_outputs_enable), 8'h01);
    $display("t_ids done");
  endtask

  // Fast acquire follows the bit; wide loop bandwidth follows the bit and the lock state
  task automatic t_fast();
    i_host.set_fast(1'b1);
    chk(8'(fast_acquire_enable), 8'h01);
    pll_locked_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk(8'(loss_of_lock_alarm), 8'h01);
    chk(8'(loop_bw_fast), 8'h01);
    pll_locked_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(8'(loss_of_lock_alarm), 8'h00);
    chk(8'(loop_bw_fast), 8'h00);
    rchk(ccr_pkg::ADDR_FAST, 8'h01);
    $display("t_fast done");
  endtask

  // Every legal monitor code, clocks stopped then restarted
  task automatic t_los();
    logic [1:0] m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 2'h0 : 2'(i + 1);
      i_host.set_los(m, m);
      chk(8'(input1_signal_loss_enable), 8'(m));
      chk(8'(input2_signal_loss_enable), 8'(m));
      repeat (100) @(negedge clk);
      chk(8'(signal_loss_monitor), 8'h00);
      in_run = 1'b0;
      repeat (100) @(negedge clk);
      chk(8'(signal_loss_monitor), 8'({2{m == 2'h3}}));
      repeat (700) @(negedge clk);
      chk(8'(signal_loss_monitor), 8'({2{m[1]}}));
      in_run = 1'b1;
      repeat (20) @(negedge clk);
      chk(8'(signal_loss_monitor), 8'h00);
    end
    i_host.set_los(2'h3, 2'h0);
    rchk(ccr_pkg::ADDR_LOS_UP, 8'h01);
    rchk(ccr_pkg::ADDR_LOS_LO, 8'hdf);
    $display("t_los done");
  endtask

  // Host trigger, then a frequency shift trigger
  task automatic t_cal();
    int n;
    // Input clocks run and lock is present here
    i_host.wr(ccr_pkg::ADDR_CTRL, 8'h40);
    chk(8'(calibration_busy), 8'h01);
    chk(8'(loss_of_lock_alarm), 8'h01);
    rchk(ccr_pkg::ADDR_CTRL, 8'h40);
    wait_idle(n);
    chk(8'(n >= ccr_pkg::CAL_RUN_CYCLES - 8), 8'h01);
    chk(8'(loss_of_lock_alarm), 8'h00);
    rchk(ccr_pkg::ADDR_CTRL, 8'h00);
    freq_shift_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(8'(calibration_busy), 8'h01);
    freq_shift_pin = 1'b0;
    wait_idle(n);
    chk(8'(loss_of_lock_alarm), 8'h00);
    $display("t_cal done");
  endtask

  // Soft reset restores defaults and gates the outputs
  task automatic t_soft();
    i_host.set_fast(1'b1);
    i_host.set_los(2'h0, 2'h2);
    i_host.wr(ccr_pkg::ADDR_CTRL, 8'h80);
    chk(8'(clock_outputs_enable), 8'h00);
    chk(8'(loss_of_lock_alarm), 8'h01);
    chk(8'(fast_acquire_enable), 8'h00);
    chk(8'(input1_signal_loss_enable), 8'h03);
    i_host.settle();
    chk(8'(clock_outputs_enable), 8'h01);
    rchk(ccr_pkg::ADDR_FAST, 8'h00);
    rchk(ccr_pkg::ADDR_LOS_UP, 8'h03);
    $display("t_soft done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_ids();
    t_fast();
    t_los();
    t_cal();
    t_soft();
    wrap_up();
  end

endmodule

`default_nettype wire
